// file: design/lgc_pkg.sv
// What this block does
// - clear select: pair 5 is PCI request/grant
// - select set, no GPIO: sideband DMA channel B
// - GPIO use-select set: pins are GPI/GPO
// - conceal set: AD22 held low to bridge
// - break enable clear: FPU error ignored in C2-C4
// - break enable set: FPU error breaks C2-C4
// - fault enable clear: no IRQ13, no ignore-numeric
// - enabled error low: IRQ13 held till F0h write
// - same condition also drives ignore-numeric-error active
package lgc_pkg;
  localparam logic [7:0] LGC_GC_OFFSET = 8'hd0;
  localparam logic [31:0] LGC_GC_RESET = 32'h0000_0000;
  localparam int LGC_PAIR_SEL_BIT = 25;
  localparam int LGC_CONCEAL_BIT = 24;
  localparam int LGC_BREAK_EN_BIT = 21;
  localparam int LGC_FAULT_EN_BIT = 13;
  // only the four implemented bits are writable and readable
  localparam logic [31:0] LGC_GC_MASK = 32'h0320_2000;
  localparam logic [15:0] LGC_FPU_CLEAR_PORT = 16'h00f0;
  localparam logic [1:0] LGC_GPIO_NONE = 2'h0;
endpackage

// file: design/lgc_oreg.sv
`timescale 1ns/1ns
module lgc_oreg #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end
endmodule

// file: design/lgc_general_control.sv
`timescale 1ns/1ns
module lgc_general_control (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic SRST,
  // configuration access
  input wire logic CFG_WR,
  input wire logic CFG_RD,
  input wire logic [7:0] CFG_ADDR,
  input wire logic [3:0] CFG_BE,
  input wire logic [31:0] CFG_WDATA,
  output logic [31:0] CFG_RDATA,
  output logic CFG_RVALID,
  // request/grant pair 5 pins
  input wire logic REQ5_N,
  output logic GNT5_N,
  input wire logic [1:0] GPIO_USE_SEL,
  // pci arbiter side
  output logic ARB_REQ5,
  input wire logic ARB_GNT5,
  // sideband dma channel b side
  output logic DMA_REQB,
  input wire logic DMA_GNTB,
  // general purpose side
  output logic GPI_REQ5,
  input wire logic GPO_GNT5,
  // configuration cycle address line
  input wire logic AD22_REQ,
  input wire logic BRIDGE_CFG_CYCLE,
  output logic AD22,
  // processor error and power state
  input wire logic FPU_ERROR_N,
  input wire logic CSTATE_DEEP,
  output logic BREAK_EVENT,
  input wire logic IO_WR,
  input wire logic [15:0] IO_ADDR,
  output logic IRQ13,
  output logic IGNORE_NUMERIC_ERROR_N
);
  logic [31:0] gc_r;
  logic [31:0] gc_nxt;
  wire hit = (CFG_ADDR[7:2] == lgc_pkg::LGC_GC_OFFSET[7:2]);
  wire [31:0] be_mask = {{8{CFG_BE[3]}}, {8{CFG_BE[2]}}, {8{CFG_BE[1]}}, {8{CFG_BE[0]}}};
  // byte lanes with their enable clear masked off on write
  // reserved bits ignored
  wire [31:0] wr_mask = be_mask & lgc_pkg::LGC_GC_MASK;
  wire wr_hit = CFG_WR && hit;

  always_comb begin
    gc_nxt = gc_r;
    if (wr_hit) begin
      gc_nxt = (gc_r & ~wr_mask) | (CFG_WDATA & wr_mask);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      gc_r <= lgc_pkg::LGC_GC_RESET;
    end else begin
      gc_r <= gc_nxt;
    end
  end

  wire pair_sel = gc_r[lgc_pkg::LGC_PAIR_SEL_BIT];
  wire conceal = gc_r[lgc_pkg::LGC_CONCEAL_BIT];
  wire break_en = gc_r[lgc_pkg::LGC_BREAK_EN_BIT];
  wire fault_en = gc_r[lgc_pkg::LGC_FAULT_EN_BIT];

  // unmapped reads answer zero, still with a valid strobe
  // reserved reads zero
  wire [31:0] rdata_nxt = (CFG_RD && hit) ? (gc_r & lgc_pkg::LGC_GC_MASK) : 32'h0000_0000;

  lgc_oreg #(.W(32), .RST(32'h0000_0000)) u_rdata (
    .clk(CLK_SYS), .srst(SRST), .d(rdata_nxt), .q(CFG_RDATA)
  );
  lgc_oreg #(.W(1), .RST(1'h0)) u_rvalid (
    .clk(CLK_SYS), .srst(SRST), .d(CFG_RD), .q(CFG_RVALID)
  );

  // pin routing; each pin goes to gpio on its own use-select bit
  // sideband only with no gpio
  wire dma_mode = pair_sel && (GPIO_USE_SEL == lgc_pkg::LGC_GPIO_NONE);
  wire req_gpio = GPIO_USE_SEL[0];
  wire gnt_gpio = GPIO_USE_SEL[1];
  wire req_pci = !req_gpio && !dma_mode;
  wire gnt_pci = !gnt_gpio && !dma_mode;

  wire arb_req_nxt = req_pci && !REQ5_N;
  wire dma_req_nxt = dma_mode && !REQ5_N;
  wire gpi_nxt = req_gpio && REQ5_N;
  wire gnt_n_nxt = gnt_gpio ? GPO_GNT5 : (dma_mode ? !DMA_GNTB : !(gnt_pci && ARB_GNT5));

  lgc_oreg #(.W(4), .RST(4'h8)) u_pair (
    .clk(CLK_SYS), .srst(SRST),
    .d({gnt_n_nxt, arb_req_nxt, dma_req_nxt, gpi_nxt}),
    .q({GNT5_N, ARB_REQ5, DMA_REQB, GPI_REQ5})
  );

  wire ad22_nxt = AD22_REQ && !(conceal && BRIDGE_CFG_CYCLE);
  lgc_oreg #(.W(1), .RST(1'h0)) u_ad22 (
    .clk(CLK_SYS), .srst(SRST), .d(ad22_nxt), .q(AD22)
  );

  wire break_nxt = break_en && CSTATE_DEEP && !FPU_ERROR_N;
  lgc_oreg #(.W(1), .RST(1'h0)) u_break (
    .clk(CLK_SYS), .srst(SRST), .d(break_nxt), .q(BREAK_EVENT)
  );

  // set wins over the port clear so an error in the clear cycle is kept
  // gated by fault enable
  wire irq_set = fault_en && !FPU_ERROR_N;
  wire irq_clr = IO_WR && (IO_ADDR == lgc_pkg::LGC_FPU_CLEAR_PORT);
  wire irq_nxt = irq_set || (IRQ13 && !irq_clr);
  lgc_oreg #(.W(1), .RST(1'h0)) u_irq (
    .clk(CLK_SYS), .srst(SRST), .d(irq_nxt), .q(IRQ13)
  );
  // ignore-numeric-error follows the held request
  // follows irq13
  lgc_oreg #(.W(1), .RST(1'h1)) u_ignore_num (
    .clk(CLK_SYS), .srst(SRST), .d(!irq_nxt), .q(IGNORE_NUMERIC_ERROR_N)
  );

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SRST);

  pci_pair_a: assert property (
    !pair_sel && (GPIO_USE_SEL == 2'h0) |=> ARB_REQ5 == !$past(REQ5_N) && GNT5_N == !$past(ARB_GNT5)
  ) else $error("pair 5 not routed to arbiter");

  dma_pair_a: assert property (
    dma_mode |=> DMA_REQB == !$past(REQ5_N) && GNT5_N == !$past(DMA_GNTB) && !ARB_REQ5
  ) else $error("pair 5 not routed to sideband dma");

  gpio_pins_a: assert property (
    (GPIO_USE_SEL == 2'h3) |=> GPI_REQ5 == $past(REQ5_N) && GNT5_N == $past(GPO_GNT5) && !DMA_REQB && !ARB_REQ5
  ) else $error("gpio pins not routed");

  ad22_hide_a: assert property (
    conceal && BRIDGE_CFG_CYCLE |=> !AD22
  ) else $error("ad22 asserted to hidden bridge");

  ad22_pass_a: assert property (
    !conceal |=> AD22 == $past(AD22_REQ)
  ) else $error("ad22 not passed through");

  break_off_a: assert property (
    !break_en |=> !BREAK_EVENT
  ) else $error("break raised while disabled");

  break_on_a: assert property (
    break_en && CSTATE_DEEP && !FPU_ERROR_N |=> BREAK_EVENT
  ) else $error("break missed while enabled");

  irq_off_a: assert property (
    !fault_en && !IRQ13 |=> !IRQ13 && IGNORE_NUMERIC_ERROR_N
  ) else $error("irq13 raised while disabled");

  irq_set_a: assert property (
    irq_set |=> IRQ13
  ) else $error("irq13 not raised");

  irq_hold_a: assert property (
    IRQ13 && !irq_clr |=> IRQ13
  ) else $error("irq13 dropped before port write");

  irq_clear_a: assert property (
    IRQ13 && irq_clr && !irq_set |=> !IRQ13
  ) else $error("irq13 not cleared by port write");

  ignore_tie_a: assert property (
    $rose(IRQ13) |-> !IGNORE_NUMERIC_ERROR_N ##1 (IGNORE_NUMERIC_ERROR_N == !IRQ13)
  ) else $error("ignore-numeric not following irq13");

  rsvd_zero_a: assert property (
    CFG_RVALID |-> (CFG_RDATA & ~lgc_pkg::LGC_GC_MASK) == 32'h0000_0000
  ) else $error("reserved bits read nonzero");

  cfg_readback_a: assert property (
    wr_hit && (CFG_BE == 4'hf) ##1 CFG_RD && hit && !CFG_WR
      |=> CFG_RDATA == ($past(CFG_WDATA, 2) & lgc_pkg::LGC_GC_MASK)
  ) else $error("readback mismatch");

  rsvd_store_a: assert property (
    wr_hit |=> (gc_r & ~lgc_pkg::LGC_GC_MASK) == 32'h0000_0000
  ) else $error("reserved bits stored");

  unmapped_read_a: assert property (
    CFG_RD && !hit |=> CFG_RVALID && CFG_RDATA == 32'h0000_0000
  ) else $error("unmapped read not zero");

  gpio_req_only_a: assert property (
    (GPIO_USE_SEL == 2'h1) |=> GPI_REQ5 == $past(REQ5_N) && !DMA_REQB && !ARB_REQ5
  ) else $error("request pin not taken as gpio");

  gpio_gnt_only_a: assert property (
    (GPIO_USE_SEL == 2'h2) |=> GNT5_N == $past(GPO_GNT5) && !GPI_REQ5 && !DMA_REQB
  ) else $error("grant pin not taken as gpio");

  ad22_other_a: assert property (
    !BRIDGE_CFG_CYCLE |=> AD22 == $past(AD22_REQ)
  ) else $error("ad22 blocked outside bridge cycles");

  break_shallow_a: assert property (
    !CSTATE_DEEP |=> !BREAK_EVENT
  ) else $error("break raised outside deep states");

  ignore_set_a: assert property (
    irq_set |=> !IGNORE_NUMERIC_ERROR_N
  ) else $error("ignore-numeric not driven");

  dma_idle_a: assert property (
    !dma_mode |=> !DMA_REQB
  ) else $error("sideband request outside dma mode");

  dma_cov_c: cover property (dma_mode && !REQ5_N ##1 DMA_REQB);
  irq_cov_c: cover property (irq_set ##1 IRQ13 ##[1:8] irq_clr ##1 !IRQ13);
  hide_cov_c: cover property (conceal && BRIDGE_CFG_CYCLE && AD22_REQ ##1 !AD22);
  break_cov_c: cover property (break_nxt ##1 BREAK_EVENT);
  pci_cov_c: cover property (!dma_mode && ARB_GNT5 ##1 !GNT5_N);
endmodule

// file: sim/lgc_far_model.sv
`timescale 1ns/1ns
module lgc_far_model (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // requests from the block
  input wire logic arb_req,
  input wire logic dma_req,
  // grants back
  output logic arb_gnt,
  output logic dma_gnt
);
  // grants lag a cycle, so the block never sees an instant answer
  always_ff @(posedge clk) begin
    arb_gnt <= !srst && arb_req;
    dma_gnt <= !srst && dma_req;
  end
endmodule

// file: sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic CLK_SYS = 0, SRST = 1, CFG_WR = 0, CFG_RD = 0, REQ5_N = 1, GPO_GNT5 = 0, IO_WR = 0;
  logic AD22_REQ = 0, BRIDGE_CFG_CYCLE = 0, FPU_ERROR_N = 1, CSTATE_DEEP = 0, ARB_GNT5, DMA_GNTB;
  logic [7:0] CFG_ADDR = 8'hd0;
  logic [3:0] CFG_BE = 4'hf;
  logic [31:0] CFG_WDATA = 32'h0, CFG_RDATA;
  logic [1:0] GPIO_USE_SEL = 2'h0;
  logic [15:0] IO_ADDR = 16'h0;
  logic CFG_RVALID, GNT5_N, ARB_REQ5, DMA_REQB, GPI_REQ5, AD22, BREAK_EVENT, IRQ13, IGNORE_NUMERIC_ERROR_N;
  int bad_count = 0, compares = 0, cycles = 0;
  always #25 CLK_SYS = !CLK_SYS;
  lgc_general_control u_dut (.CLK_SYS(CLK_SYS), .SRST(SRST), .CFG_WR(CFG_WR), .CFG_RD(CFG_RD),
    .CFG_ADDR(CFG_ADDR), .CFG_BE(CFG_BE), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA),
    .CFG_RVALID(CFG_RVALID), .REQ5_N(REQ5_N), .GNT5_N(GNT5_N), .GPIO_USE_SEL(GPIO_USE_SEL),
    .ARB_REQ5(ARB_REQ5), .ARB_GNT5(ARB_GNT5), .DMA_REQB(DMA_REQB), .DMA_GNTB(DMA_GNTB),
    .GPI_REQ5(GPI_REQ5), .GPO_GNT5(GPO_GNT5), .AD22_REQ(AD22_REQ), .BRIDGE_CFG_CYCLE(BRIDGE_CFG_CYCLE),
    .AD22(AD22), .FPU_ERROR_N(FPU_ERROR_N), .CSTATE_DEEP(CSTATE_DEEP), .BREAK_EVENT(BREAK_EVENT),
    .IO_WR(IO_WR), .IO_ADDR(IO_ADDR), .IRQ13(IRQ13), .IGNORE_NUMERIC_ERROR_N(IGNORE_NUMERIC_ERROR_N));
  lgc_far_model u_far (.clk(CLK_SYS), .srst(SRST), .arb_req(ARB_REQ5), .dma_req(DMA_REQB),
    .arb_gnt(ARB_GNT5), .dma_gnt(DMA_GNTB));
  task step(input int n);
    repeat (n) @(posedge CLK_SYS);
    #2;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    CFG_ADDR = a;
    CFG_BE = be;
    CFG_WDATA = d;
    CFG_WR = 1;
    step(1);
    CFG_WR = 0;
  endtask
  // read data is looked at in its one valid cycle
  task rd(input logic [7:0] a, input logic [31:0] exp);
    CFG_ADDR = a;
    CFG_RD = 1;
    step(1);
    CFG_RD = 0;
    chk("rvalid", 32'h1, {31'h0, CFG_RVALID});
    chk("rdata", exp, CFG_RDATA);
  endtask
  task tally_and_finish;
    if (bad_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // a hang ends the run as a mismatch
  always @(posedge CLK_SYS) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      tally_and_finish;
    end
  end
  initial begin
    step(6);
    SRST = 0;
    step(1);
    rd(8'hd0, 32'h0);
    wr(8'hd0, 4'hf, 32'hffff_ffff);
    rd(8'hd0, 32'h0320_2000);
    step(1);
    rd(8'hd4, 32'h0);
    REQ5_N = 0;
    step(3);
    chk("dma_reqb", 32'h1, {31'h0, DMA_REQB});
    chk("gnt5_dma", 32'h0, {31'h0, GNT5_N});
    GPIO_USE_SEL = 2'h3;
    GPO_GNT5 = 1;
    step(1);
    chk("dma_off", 32'h0, {31'h0, DMA_REQB});
    chk("gnt5_gpo", 32'h1, {31'h0, GNT5_N});
    chk("gpi_req5", 32'h0, {31'h0, GPI_REQ5});
    GPIO_USE_SEL = 2'h1;
    REQ5_N = 1;
    step(1);
    chk("gpi_high", 32'h1, {31'h0, GPI_REQ5});
    chk("arb_off_gpi", 32'h0, {31'h0, ARB_REQ5});
    GPIO_USE_SEL = 2'h2;
    GPO_GNT5 = 0;
    REQ5_N = 0;
    step(1);
    chk("gnt5_gpo_low", 32'h0, {31'h0, GNT5_N});
    chk("gpi_off", 32'h0, {31'h0, GPI_REQ5});
    GPIO_USE_SEL = 2'h0;
    AD22_REQ = 1;
    BRIDGE_CFG_CYCLE = 1;
    step(1);
    chk("ad22_hid", 32'h0, {31'h0, AD22});
    // top lane only: clears select and conceal, keeps the rest
    wr(8'hd0, 4'h8, 32'h0);
    step(1);
    chk("ad22_on", 32'h1, {31'h0, AD22});
    step(2);
    chk("arb_req5", 32'h1, {31'h0, ARB_REQ5});
    chk("gnt5_pci", 32'h0, {31'h0, GNT5_N});
    rd(8'hd0, 32'h0020_2000);
    CSTATE_DEEP = 1;
    FPU_ERROR_N = 0;
    step(1);
    chk("break_on", 32'h1, {31'h0, BREAK_EVENT});
    chk("irq13_set", 32'h1, {31'h0, IRQ13});
    chk("ignore_on", 32'h0, {31'h0, IGNORE_NUMERIC_ERROR_N});
    FPU_ERROR_N = 1;
    step(2);
    chk("irq13_held", 32'h1, {31'h0, IRQ13});
    IO_ADDR = 16'h00f0;
    IO_WR = 1;
    step(1);
    IO_WR = 0;
    step(1);
    chk("irq13_clr", 32'h0, {31'h0, IRQ13});
    chk("ignore_clr", 32'h1, {31'h0, IGNORE_NUMERIC_ERROR_N});
    wr(8'hd0, 4'hf, 32'h0);
    FPU_ERROR_N = 0;
    step(2);
    chk("break_off", 32'h0, {31'h0, BREAK_EVENT});
    chk("irq13_off", 32'h0, {31'h0, IRQ13});
    chk("ignore_off", 32'h1, {31'h0, IGNORE_NUMERIC_ERROR_N});
    // mid-run reset with irq13 held and the sideband dma route busy
    wr(8'hd0, 4'hf, 32'hffff_ffff);
    step(1);
    chk("irq13_pre", 32'h1, {31'h0, IRQ13});
    SRST = 1;
    step(1);
    chk("irq13_rst", 32'h0, {31'h0, IRQ13});
    chk("ignore_rst", 32'h1, {31'h0, IGNORE_NUMERIC_ERROR_N});
    chk("break_rst", 32'h0, {31'h0, BREAK_EVENT});
    chk("dma_rst", 32'h0, {31'h0, DMA_REQB});
    chk("gnt5_rst", 32'h1, {31'h0, GNT5_N});
    chk("ad22_rst", 32'h0, {31'h0, AD22});
    SRST = 0;
    step(1);
    chk("irq13_after", 32'h0, {31'h0, IRQ13});
    rd(8'hd0, 32'h0);
    tally_and_finish;
  end
endmodule
